// File: src/tcoc_top.v
// Timer compare-output control: 16-bit counter, compare channels A and B,
// waveform modes and pin override, with an AHB-Lite register slave.
// Assumes a single master; port pins are resolved by the port logic outside.
//
// The implementer's own choices: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
`include "tcoc_defs.vh"
module tcoc_top (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // Compare output pins
  output reg cmp_output_a,
  output reg cmp_output_b,
  output reg cmp_output_a_ovr,
  output reg cmp_output_b_ovr
);
  localparam DIR_UP = 1'b1;
  localparam DIR_DOWN = 1'b0;

  reg [7:0] timer_ctrl_a_q;
  reg [1:0] wave_mode_high_q;
  reg [1:0] timer_ctrl_d_q;
  reg [15:0] cmp_buf_a_q;
  reg [15:0] cmp_buf_b_q;
  reg [15:0] cmp_act_a_q;
  reg [15:0] cmp_act_b_q;
  reg [15:0] top_reg_q;
  reg [7:0] presc_q;
  reg [7:0] presc_cnt_q;
  reg [15:0] timer_count_q;
  reg dir_q;
  reg [1:0] cmp_match_flags_q;
  reg overflow_flag_q;
  reg wr_pend_q;
  reg [7:0] wr_addr_q;
  wire [3:0] wave_mode;
  wire [1:0] wclass;
  wire [15:0] top_val;
  wire timer_tick;
  wire at_top;
  wire at_bottom;
  wire bus_req;
  wire [7:0] raddr;
  wire wave_a;
  wire wave_b;
  wire conn_a;
  wire conn_b;
  wire dual_slope;
  wire load_at_bottom;
  wire immediate;

  // Wave mode classification, shared by both channels
  function [1:0] mode_class;
    input [3:0] m;
    begin
      if (m == `TCOC_WM_NORMAL || m == `TCOC_WM_CTC_OCR || m == `TCOC_WM_CTC_ICR) begin
        mode_class = `TCOC_CL_NONPWM;
      end else if (m == `TCOC_WM_FAST_8 || m == `TCOC_WM_FAST_9 ||
                   m == `TCOC_WM_FAST_10 || m == `TCOC_WM_FAST_ICR ||
                   m == `TCOC_WM_FAST_OCR) begin
        mode_class = `TCOC_CL_FAST;
      end else begin
        mode_class = `TCOC_CL_PHASE;
      end
    end
  endfunction

  assign wave_mode = {wave_mode_high_q, timer_ctrl_a_q[`TCOC_WGM_LOW_HI:`TCOC_WGM_LOW_LO]};
  assign wclass = mode_class(wave_mode);
  assign dual_slope = (wclass == `TCOC_CL_PHASE);
  assign load_at_bottom = (wave_mode == `TCOC_WM_PFC_ICR) || (wave_mode == `TCOC_WM_PFC_OCR);
  assign immediate = (wclass == `TCOC_CL_NONPWM);

  // TOP selection: fixed widths, else programmed TOP register
  assign top_val = (wave_mode == `TCOC_WM_NORMAL) ? `TCOC_TOP_MAX :
    (wave_mode[1:0] == 2'h1 && !wave_mode[3]) ? `TCOC_TOP_8 :
    (wave_mode[1:0] == 2'h2 && !wave_mode[3]) ? `TCOC_TOP_9 :
    (wave_mode[1:0] == 2'h3 && !wave_mode[3] && wave_mode != `TCOC_WM_FAST_10) ?
    `TCOC_TOP_10 : (wave_mode == `TCOC_WM_FAST_10) ? `TCOC_TOP_10 : top_reg_q;

  // Tick is a one-cycle enable from the prescaler, never a clock
  assign timer_tick = (presc_cnt_q == presc_q);
  assign at_top = timer_tick && (timer_count_q == top_val);
  assign at_bottom = timer_tick && (timer_count_q == `TCOC_BOTTOM);

  // Prescaler and counter, all on hclk
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_cnt_q <= `TCOC_RST_8;
      timer_count_q <= `TCOC_RST_16;
      dir_q <= DIR_UP;
    end else begin
      presc_cnt_q <= timer_tick ? `TCOC_RST_8 : presc_cnt_q + `TCOC_ONE8;
      if (timer_tick) begin
        if (dual_slope) begin
          if (timer_count_q == top_val) begin
            dir_q <= DIR_DOWN;
            timer_count_q <= timer_count_q - `TCOC_ONE16;
          end else if (timer_count_q == `TCOC_BOTTOM) begin
            dir_q <= DIR_UP;
            timer_count_q <= timer_count_q + `TCOC_ONE16;
          end else if (dir_q == DIR_UP) begin
            timer_count_q <= timer_count_q + `TCOC_ONE16;
          end else begin
            timer_count_q <= timer_count_q - `TCOC_ONE16;
          end
        end else begin
          dir_q <= DIR_UP;
          timer_count_q <= (timer_count_q >= top_val) ? `TCOC_BOTTOM :
            timer_count_q + `TCOC_ONE16;
        end
      end
    end
  end

  // Active compare update: immediate, at TOP, or at BOTTOM
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_act_a_q <= `TCOC_RST_16;
      cmp_act_b_q <= `TCOC_RST_16;
    end else if (immediate || (load_at_bottom ? at_bottom : at_top)) begin
      cmp_act_a_q <= cmp_buf_a_q;
      cmp_act_b_q <= cmp_buf_b_q;
    end
  end

  // Direction seen by the compare unit at the turning points.
  // A match at TOP acts as a down-count match, and one at BOTTOM as an up-count match.
  // This way a compare value at either end holds the output at a steady level.
  wire up_now;
  assign up_now = (timer_count_q == top_val) ? DIR_DOWN :
    (timer_count_q == `TCOC_BOTTOM) ? DIR_UP : dir_q;

  // Channel A waveform
  tcoc_wave_unit u_wave_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .com(timer_ctrl_a_q[`TCOC_COM_A_HI:`TCOC_COM_A_LO]),
    .wclass(wclass),
    .wgm_top_bit(wave_mode[3]),
    .is_chan_a(1'b1),
    .out_en(timer_ctrl_d_q[`TCOC_OEN_A]),
    .match(timer_tick && timer_count_q == cmp_act_a_q),
    .match_is_top(cmp_act_a_q == top_val),
    .at_top(at_top),
    .counting_up(up_now),
    .wave_q(wave_a),
    .connected(conn_a)
  );

  // Channel B waveform
  tcoc_wave_unit u_wave_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .com(timer_ctrl_a_q[`TCOC_COM_B_HI:`TCOC_COM_B_LO]),
    .wclass(wclass),
    .wgm_top_bit(wave_mode[3]),
    .is_chan_a(1'b0),
    .out_en(timer_ctrl_d_q[`TCOC_OEN_B]),
    .match(timer_tick && timer_count_q == cmp_act_b_q),
    .match_is_top(cmp_act_b_q == top_val),
    .at_top(at_top),
    .counting_up(up_now),
    .wave_q(wave_b),
    .connected(conn_b)
  );

  // Pin outputs registered; zero level when disconnected
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_output_a <= 1'b0;
      cmp_output_b <= 1'b0;
      cmp_output_a_ovr <= 1'b0;
      cmp_output_b_ovr <= 1'b0;
    end else begin
      cmp_output_a <= conn_a & wave_a;
      cmp_output_b <= conn_b & wave_b;
      cmp_output_a_ovr <= conn_a;
      cmp_output_b_ovr <= conn_b;
    end
  end

  // Status flags: hardware set wins over software write-one-to-clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cmp_match_flags_q <= 2'h0;
      overflow_flag_q <= 1'b0;
    end else begin
      cmp_match_flags_q[0] <= (timer_tick && timer_count_q == cmp_act_a_q) ||
        (cmp_match_flags_q[0] && !(wr_pend_q && wr_addr_q == `TCOC_ADDR_STATUS && hwdata[0]));
      cmp_match_flags_q[1] <= (timer_tick && timer_count_q == cmp_act_b_q) ||
        (cmp_match_flags_q[1] && !(wr_pend_q && wr_addr_q == `TCOC_ADDR_STATUS && hwdata[1]));
      overflow_flag_q <= (dual_slope || load_at_bottom ? at_bottom : at_top) ||
        (overflow_flag_q && !(wr_pend_q && wr_addr_q == `TCOC_ADDR_STATUS && hwdata[2]));
    end
  end

  // AHB address phase capture; zero wait states
  assign bus_req = hsel && hready && htrans[1];
  assign raddr = haddr[`TCOC_ADDR_BITS-1:0];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= `TCOC_RST_8;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        wr_pend_q <= bus_req && hwrite;
        wr_addr_q <= raddr;
      end
    end
  end

  // Register writes in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_ctrl_a_q <= `TCOC_RST_8;
      wave_mode_high_q <= 2'h0;
      timer_ctrl_d_q <= 2'h0;
      cmp_buf_a_q <= `TCOC_RST_16;
      cmp_buf_b_q <= `TCOC_RST_16;
      top_reg_q <= `TCOC_TOP_RST;
      presc_q <= `TCOC_RST_8;
    end else if (wr_pend_q) begin
      if (wr_addr_q == `TCOC_ADDR_CTRL_A) begin
        timer_ctrl_a_q <= hwdata[7:0] & `TCOC_CTRL_A_WMASK;
      end else if (wr_addr_q == `TCOC_ADDR_CTRL_B) begin
        wave_mode_high_q <= hwdata[`TCOC_WGM_HIGH_HI:`TCOC_WGM_HIGH_LO];
      end else if (wr_addr_q == `TCOC_ADDR_CTRL_D) begin
        timer_ctrl_d_q <= hwdata[1:0];
      end else if (wr_addr_q == `TCOC_ADDR_CMP_A) begin
        cmp_buf_a_q <= hwdata[15:0];
      end else if (wr_addr_q == `TCOC_ADDR_CMP_B) begin
        cmp_buf_b_q <= hwdata[15:0];
      end else if (wr_addr_q == `TCOC_ADDR_TOP) begin
        top_reg_q <= hwdata[15:0];
      end else if (wr_addr_q == `TCOC_ADDR_PRESC) begin
        presc_q <= hwdata[7:0];
      end
    end
  end

  // Read data registered at the address phase; unmapped reads zero
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (bus_req && !hwrite) begin
      if (raddr == `TCOC_ADDR_CTRL_A) begin
        hrdata <= {24'h000000, timer_ctrl_a_q};
      end else if (raddr == `TCOC_ADDR_CTRL_B) begin
        hrdata <= {30'h00000000, wave_mode_high_q};
      end else if (raddr == `TCOC_ADDR_CTRL_D) begin
        hrdata <= {30'h00000000, timer_ctrl_d_q};
      end else if (raddr == `TCOC_ADDR_CMP_A) begin
        hrdata <= {16'h0000, cmp_buf_a_q};
      end else if (raddr == `TCOC_ADDR_CMP_B) begin
        hrdata <= {16'h0000, cmp_buf_b_q};
      end else if (raddr == `TCOC_ADDR_TOP) begin
        hrdata <= {16'h0000, top_reg_q};
      end else if (raddr == `TCOC_ADDR_STATUS) begin
        hrdata <= {timer_count_q, 12'h000, dir_q, overflow_flag_q, cmp_match_flags_q};
      end else if (raddr == `TCOC_ADDR_PRESC) begin
        hrdata <= {24'h000000, presc_q};
      end else begin
        hrdata <= 32'h00000000;
      end
    end
  end
endmodule // tcoc_top

// File: src/tcoc_defs.vh
// Constants for the timer compare-output control block.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef TCOC_DEFS_VH
`define TCOC_DEFS_VH
// Register byte addresses on the AHB-Lite slave
`define TCOC_ADDR_CTRL_A 8'h00
`define TCOC_ADDR_CTRL_B 8'h04
`define TCOC_ADDR_CTRL_D 8'h08
`define TCOC_ADDR_CMP_A 8'h0C
`define TCOC_ADDR_CMP_B 8'h10
`define TCOC_ADDR_TOP 8'h14
`define TCOC_ADDR_STATUS 8'h18
`define TCOC_ADDR_PRESC 8'h1C
// Field positions of timer_ctrl_a
`define TCOC_COM_A_HI 7
`define TCOC_COM_A_LO 6
`define TCOC_COM_B_HI 5
`define TCOC_COM_B_LO 4
`define TCOC_WGM_LOW_HI 1
`define TCOC_WGM_LOW_LO 0
`define TCOC_CTRL_A_WMASK 8'hF3
// Field positions of timer_ctrl_b (upper wave mode bits)
`define TCOC_WGM_HIGH_HI 1
`define TCOC_WGM_HIGH_LO 0
// Field positions of timer_ctrl_d (per-channel output enables)
`define TCOC_OEN_A 0
`define TCOC_OEN_B 1
// Reset values
`define TCOC_RST_8 8'h00
`define TCOC_RST_16 16'h0000
`define TCOC_TOP_RST 16'hFFFF
// Compare output mode codes
`define TCOC_COM_OFF 2'h0
`define TCOC_COM_TGL 2'h1
`define TCOC_COM_CLR 2'h2
`define TCOC_COM_SET 2'h3
// Wave mode codes
`define TCOC_WM_NORMAL 4'h0
`define TCOC_WM_CTC_OCR 4'h4
`define TCOC_WM_CTC_ICR 4'hC
`define TCOC_WM_FAST_8 4'h5
`define TCOC_WM_FAST_9 4'h6
`define TCOC_WM_FAST_10 4'h7
`define TCOC_WM_FAST_ICR 4'hE
`define TCOC_WM_FAST_OCR 4'hF
`define TCOC_WM_PFC_ICR 4'h8
`define TCOC_WM_PFC_OCR 4'h9
// Wave mode classes
`define TCOC_CL_NONPWM 2'h0
`define TCOC_CL_FAST 2'h1
`define TCOC_CL_PHASE 2'h2
// Fixed TOP values
`define TCOC_TOP_8 16'h00FF
`define TCOC_TOP_9 16'h01FF
`define TCOC_TOP_10 16'h03FF
`define TCOC_TOP_MAX 16'hFFFF
`define TCOC_BOTTOM 16'h0000
`define TCOC_ONE16 16'h0001
`define TCOC_ONE8 8'h01
// AHB constants
`define TCOC_HTRANS_NONSEQ 2'h2
`define TCOC_HTRANS_SEQ 2'h3
`define TCOC_ADDR_BITS 8
`endif

// File: src/tcoc_wave_unit.v
// One compare-output waveform channel: decodes mode and class into the next
// output level. Assumes tick-qualified match and TOP strobes from the counter.
`timescale 1ns/1ps
`include "tcoc_defs.vh"
module tcoc_wave_unit (
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Configuration
  input wire [1:0] com,
  input wire [1:0] wclass,
  input wire wgm_top_bit,
  input wire is_chan_a,
  input wire out_en,
  // Counter events; match and at_top qualified by the timer tick
  input wire match,
  input wire match_is_top,
  input wire at_top,
  input wire counting_up,
  // Waveform and pin override
  output reg wave_q,
  output wire connected
);
  reg wave_d;
  wire toggle_ok;

  // Pin is taken over only with the enable set and a nonzero mode
  assign toggle_ok = is_chan_a & wgm_top_bit;
  assign connected = out_en & (com != `TCOC_COM_OFF) &
    ((wclass == `TCOC_CL_NONPWM) | (com != `TCOC_COM_TGL) | toggle_ok);

  // Next waveform level by mode class
  always @* begin
    wave_d = wave_q;
    case (wclass)
      `TCOC_CL_NONPWM: begin
        if (match) begin
          case (com)
            `TCOC_COM_TGL: wave_d = ~wave_q;
            `TCOC_COM_CLR: wave_d = 1'b0;
            `TCOC_COM_SET: wave_d = 1'b1;
            default: wave_d = wave_q;
          endcase
        end
      end
      `TCOC_CL_FAST: begin
        if (com == `TCOC_COM_TGL) begin
          if (match && toggle_ok) wave_d = ~wave_q;
        end else if (com[1]) begin
          // Match at TOP is ignored; the TOP action wins
          if (at_top) wave_d = ~com[0];
          else if (match && !match_is_top) wave_d = com[0];
        end
      end
      `TCOC_CL_PHASE: begin
        if (com == `TCOC_COM_TGL) begin
          if (match && toggle_ok) wave_d = ~wave_q;
        end else if (com[1] && match) begin
          // Up: clear for 10, set for 11; down: the opposite
          wave_d = counting_up ? com[0] : ~com[0];
        end
      end
      default: wave_d = wave_q;
    endcase
  end

  // Waveform register
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end
endmodule // tcoc_wave_unit

// File: bench/tcoc_checker.sv
// Checker for the compare-output block; shadows configuration from bus writes.
// Assumes zero-wait AHB-Lite transfers from a single master.
`timescale 1ns/1ps
module tcoc_checker (
  // Clock, reset and bus
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  // Compare outputs
  input wire cmp_output_a,
  input wire cmp_output_b,
  input wire cmp_output_a_ovr,
  input wire cmp_output_b_ovr
);
  logic wr_q, rd_q;
  logic [7:0] adr_q, ctl_q;
  logic [1:0] up_q, oen_q;
  logic [3:0] age_q;
  wire take = hsel && hready && htrans[1];
  wire [3:0] wm = {up_q, ctl_q[1:0]};
  wire pwm = !(wm == 4'h0 || wm == 4'h4 || wm == 4'hC);
  wire [1:0] ca = ctl_q[7:6];
  wire [1:0] cb = ctl_q[5:4];
  wire exp_a = oen_q[0] && ca != 2'h0 && !(pwm && ca == 2'h1 && !wm[3]);
  wire exp_b = oen_q[1] && cb != 2'h0 && !(pwm && cb == 2'h1);
  // Configuration settled for four cycles and no write landing
  wire calm = age_q[3:2] != 2'h0 && !wr_q;
  default clocking dflt @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Shadow registers and age since the last write
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'h0;
      rd_q <= 1'h0;
      adr_q <= 8'h00;
      ctl_q <= 8'h00;
      up_q <= 2'h0;
      oen_q <= 2'h0;
      age_q <= 4'h0;
    end else begin
      wr_q <= take && hwrite;
      rd_q <= take && !hwrite && haddr[7:0] == 8'h00;
      adr_q <= haddr[7:0];
      age_q <= wr_q ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
      if (wr_q && adr_q == 8'h00) ctl_q <= hwdata[7:0] & 8'hF3;
      if (wr_q && adr_q == 8'h04) up_q <= hwdata[1:0];
      if (wr_q && adr_q == 8'h08) oen_q <= hwdata[1:0];
    end
  end
  property p_ovr_a;
    calm |-> cmp_output_a_ovr == exp_a;
  endproperty
  a_ovr_a: assert property (p_ovr_a) else $error("A override wrong");
  property p_ovr_b;
    calm |-> cmp_output_b_ovr == exp_b;
  endproperty
  a_ovr_b: assert property (p_ovr_b) else $error("B override wrong");
  property p_disc_a;
    calm && !cmp_output_a_ovr |-> !cmp_output_a;
  endproperty
  a_disc_a: assert property (p_disc_a) else $error("A drives while off");
  property p_disc_b;
    calm && !cmp_output_b_ovr |-> !cmp_output_b;
  endproperty
  a_disc_b: assert property (p_disc_b) else $error("B drives while off");
  property p_set_hold;
    calm && !pwm && ca == 2'h3 && exp_a && cmp_output_a |=> cmp_output_a;
  endproperty
  a_set_hold: assert property (p_set_hold) else $error("A set level lost");
  property p_clr_hold;
    calm && !pwm && ca == 2'h2 && exp_a |-> !$rose(cmp_output_a);
  endproperty
  a_clr_hold: assert property (p_clr_hold) else $error("A rose in clear mode");
  property p_rsvd;
    rd_q |-> hrdata[3:2] == 2'h0 && hrdata[31:8] == 24'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_readback;
    rd_q |-> hrdata[7:0] == ctl_q;
  endproperty
  a_readback: assert property (p_readback) else $error("control readback wrong");
endmodule // tcoc_checker

bind tcoc_top tcoc_checker u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .hrdata, .cmp_output_a, .cmp_output_b, .cmp_output_a_ovr, .cmp_output_b_ovr);

// File: bench/tcoc_pin_model.sv
// Port pin drivers beside the timer: each pin follows its port latch or the
// timer output. Assumes a pull-up holds an undriven pin high.
`timescale 1ns/1ps
module tcoc_pin_model (
  // Port settings from software
  input wire [1:0] dir,
  input wire [1:0] port_out,
  // Timer levels and overrides, bit 0 is channel A
  input wire [1:0] wave,
  input wire [1:0] ovr,
  // Pin levels
  output wire [1:0] pin
);
  // Driver on only with direction set; override selects the timer level
  assign pin = (dir & ((ovr & wave) | (~ovr & port_out))) | ~dir;
endmodule // tcoc_pin_model

// File: bench/tcoc_top_test.sv
// Self-checking bench for the compare-output block over AHB-Lite.
// Assumes a zero-wait slave; pins resolved by the port model.
`timescale 1ns/1ps
module tcoc_top_test;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] dir = 2'h3;
  logic [1:0] port_out = 2'h2;
  wire hready, hresp, out_a, out_b, ovr_a, ovr_b;
  wire [31:0] hrdata;
  wire [1:0] pin;
  int errors = 0;
  int check_count = 0;
  int ha, hb, hi;
  int ea[4] = '{0, 32, 0, 64};
  int fa[4] = '{0, 32, 16, 48};
  int fb[4] = '{0, 0, 64, 0};
  logic [31:0] r;
  tcoc_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .cmp_output_a(out_a),
    .cmp_output_b(out_b), .cmp_output_a_ovr(ovr_a), .cmp_output_b_ovr(ovr_b));
  tcoc_pin_model u_pins (.dir(dir), .port_out(port_out), .wave({out_b, out_a}),
    .ovr({ovr_b, ovr_a}), .pin(pin));
  // Clock of 4 ns
  initial begin
    forever #2 hclk = ~hclk;
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Wait for hready at a rising edge, bounded
  task rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'h1 && n < 50) begin
      @(posedge hclk);
      n++;
    end
    if (n == 50) errors++;
  endtask
  // One single-word transfer; read data lands in r
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    rdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    r = hrdata;
  endtask
  // Mode bits go in early so the counter never overshoots a small TOP
  task cfg(input logic [7:0] ctl, input logic [1:0] up, input logic [1:0] oen,
    input logic [15:0] ca, input logic [15:0] cb);
    bus(1'h1, 8'h0C, {16'h0, ca});
    bus(1'h1, 8'h04, {30'h0, up});
    bus(1'h1, 8'h10, {16'h0, cb});
    bus(1'h1, 8'h14, 32'h1F);
    bus(1'h1, 8'h08, {30'h0, oen});
    bus(1'h1, 8'h00, {24'h0, ctl});
    repeat (140) @(posedge hclk);
  endtask
  // Count high cycles of both outputs
  task meas(input int n);
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(negedge hclk);
      ha += int'(out_a === 1'h1);
      hb += int'(out_b === 1'h1);
    end
  endtask
  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Watchdog well beyond the expected 3800 cycles
  initial begin
    #80000;
    errors++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'h1;
    chk({30'h0, ovr_b, ovr_a}, 32'h0);
    bus(1'h0, 8'h00, 32'h0);
    chk(r, 32'h0);
    // Clear-on-match mode, every output mode with and without enable
    for (int e = 0; e < 4; e += 3) begin
      for (int c = 0; c < 4; c++) begin
        cfg(8'(c * 8'h50), 2'h1, 2'(e), 16'h0F, 16'h07);
        chk({31'h0, ovr_a}, {31'h0, e != 0 && c != 0});
        meas(64);
        chk(ha, e ? ea[c] : 0);
        chk(hb, e ? ea[c] : 0);
        if (c != 1) chk({30'h0, pin}, e == 0 || c == 0 ? 32'h2 : (c == 3 ? 32'h3 : 32'h0));
      end
    end
    $display("Test non-PWM done");
    // Fast PWM with TOP from register, compare B at TOP
    for (int c = 1; c < 4; c++) begin
      cfg(8'(c * 8'h50 + 2), 2'h3, 2'h3, 16'h07, 16'h1F);
      chk({30'h0, ovr_b, ovr_a}, c == 1 ? 32'h1 : 32'h3);
      meas(64);
      chk(ha, fa[c]);
      chk(hb, fb[c]);
    end
    $display("Test fast PWM done");
    // Phase correct, then phase and frequency correct
    for (int m = 0; m < 2; m++) begin
      for (int c = 2; c < 4; c++) begin
        cfg(8'(c * 8'h50 + 2 - 2 * m), 2'h2, 2'h3, m ? 16'h08 : 16'h00, m ? 16'h00 : 16'h1F);
        meas(124);
        chk(ha, m ? (c == 2 ? 32 : 92) : (c == 2 ? 0 : 124));
        chk(hb, ((c == 2) ^ m) ? 124 : 0);
        if (m && c == 3) chk(hi + ha, 124);
        if (m && c == 3) chk({31'h0, hi < ha}, 32'h1);
        hi = ha;
      end
    end
    $display("Test phase PWM done");
    // Toggle mode in 8-bit fast PWM stays disconnected
    cfg(8'h51, 2'h1, 2'h3, 16'h07, 16'h07);
    chk({30'h0, ovr_b, ovr_a}, 32'h0);
    bus(1'h1, 8'h00, 32'hFF);
    bus(1'h0, 8'h00, 32'h0);
    chk(r, 32'hF3);
    bus(1'h0, 8'h40, 32'h0);
    chk(r, 32'h0);
    chk({30'h0, hresp, hready}, 32'h1);
    dir <= 2'h0;
    @(posedge hclk);
    @(negedge hclk);
    chk({30'h0, pin}, 32'h3);
    $display("Test registers done");
    end_of_test();
  end
endmodule // tcoc_top_test
